//--- rtl/pct_regs.vh
/*
  Register indices, field positions and reset values of the power-on
  configuration and test control register bank.
  Assumes a 32-bit APB slave; each 64-bit register is two words.
*/
`ifndef PCT_REGS_VH
`define PCT_REGS_VH

// Register indices; byte address of the low word is four times the index
`define PCT_IDX_POWERON      10'h02a
`define PCT_IDX_TEST_CONTROL     10'h033
`define PCT_IDX_UPDATE_TRIG  10'h079
`define PCT_IDX_CHUNK0       10'h088
`define PCT_IDX_CHUNK1       10'h089
// Upper word of a 64-bit register sits at the low word's address plus this
`define PCT_HI_OFS           12'h400
`define PCT_ADDR_W           12

// Power-on configuration fields
`define PCT_CFG_DATA_CHK     1
`define PCT_CFG_RESP_CHK     2
`define PCT_CFG_ADDR_ERR_DRV 3
`define PCT_CFG_BUS_ERROR_LINE_REQ     4
`define PCT_CFG_BUS_ERROR_LINE_INT     6
`define PCT_CFG_BUS_INIT_LINE_DRV    7
`define PCT_CFG_TRISTATE     8
`define PCT_CFG_BIST         9
`define PCT_CFG_ADDR_ERR_OBS 10
`define PCT_CFG_BUS_INIT_LINE_OBS    12
`define PCT_CFG_IOQ_ONE      13
`define PCT_CFG_VEC_1MB      14
`define PCT_CFG_FRC_MODE     15
`define PCT_CFG_CLUSTER_LSB  16
`define PCT_CFG_BUSFREQ_LSB  18
`define PCT_CFG_ARB_ID_LSB   20
`define PCT_CFG_RATIO_LSB    22
`define PCT_CFG_LOW_POWER    26
`define PCT_CFG_RATIO_HI     27
`define PCT_CFG_RW_MASK      32'h040000de
`define PCT_CFG_RO_MASK      32'h0ffff700
`define PCT_CFG_RW_RESET     32'h00000000

// Bus frequency field codes
`define PCT_BUSFREQ_66       2'h0
`define PCT_BUSFREQ_100      2'h2
`define PCT_BUSFREQ_133      2'h1
`define PCT_BUSFREQ_RSVD     2'h3

// Test control fields
`define PCT_TC_STREAM_DIS    30
`define PCT_TC_SPLIT_LOCK    31
`define PCT_TC_RW_MASK       32'hc0000000
`define PCT_TC_RESET         32'h00000000

`endif

//--- rtl/pct_strap_latch.v
/*
  Captures the power-on strap word once, on the first clock after reset
  is released, and holds it until the next reset.
  Assumes straps are stable around reset release.
*/
`timescale 1ns/1ps
module pct_strap_latch #(
  parameter W = 32
) (
  input  wire         clk_in,
  input  wire         rst_in,
  input  wire [W-1:0] strap_in,
  output wire [W-1:0] strap_out,
  output wire         captured_out
);
  reg [W-1:0] strap_ff;
  reg         done_ff;

  // Sampled after release: a synchronous reset only loads constants
  always @(posedge clk_in) begin
    if (rst_in) begin
      strap_ff <= {W{1'b0}};
      done_ff  <= 1'b0;
    end else if (!done_ff) begin
      strap_ff <= strap_in;
      done_ff  <= 1'b1;
    end
  end

  assign strap_out    = strap_ff;
  assign captured_out = done_ff;
endmodule // pct_strap_latch

//--- rtl/pct_ctl.v
/*
  Power-on configuration and test control register bank with APB slave,
  strap capture, bus error output gating and cache chunk data storage.
  Assumes a 32-bit APB master; straps stable at reset release; the error
  and lock request inputs are synchronous to clk_in.
*/
// How it works
// - Configuration register accepts enable writes; reads return configuration in force.
// - Bit 1 enables checking of bus data errors.
// - Bit 2 enables response error checking and redundancy-checker error input.
// - Bit 4 lets bus error line assert for requests this device initiates.
// - Bit 6 gates internal-error bus error; bits 3, 7 gate address error, bus init.
// - Read-only bit 13: 1 means queue depth one, 0 means eight.
// - Read-only bit 14: 1 means reset vector near 1 MB, else 4 GB.
// - Read-only bits 19:18 give bus frequency 66, 133, 100, reserved.
// - Bit 26 enables low power mode when written 1 or when its strap is 1.
// - Test control bit 31 suppresses bus lock for split locked accesses.
// - Two 64-bit chunk registers hold second-level cache data, one per chunk.
`timescale 1ns/1ps
`include "pct_regs.vh"
module pct_ctl (
  input  wire                   clk_in,
  input  wire                   rst_in,
  // APB slave
  input  wire                   psel_in,
  input  wire                   penable_in,
  input  wire                   pwrite_in,
  input  wire [`PCT_ADDR_W-1:0] paddr_in,
  input  wire [31:0]            pwdata_in,
  input  wire [3:0]             pstrb_in,
  output wire                   pready_out,
  output reg  [31:0]            prdata_out,
  output reg                    pslverr_out,
  // Power-on straps, bit positions as in the configuration register
  input  wire [31:0]            strap_cfg_in,
  // Error and lock requests from the core
  input  wire                   data_err_in,
  input  wire                   resp_err_in,
  input  wire                   redundancy_checker_error_input_in,
  input  wire                   addr_err_req_in,
  input  wire                   bus_error_line_req_initiator_in,
  input  wire                   bus_error_line_req_internal_in,
  input  wire                   bus_init_line_req_in,
  input  wire                   lock_req_in,
  input  wire                   lock_split_in,
  // Gated outputs
  output reg                    data_err_flag_out,
  output reg                    resp_err_flag_out,
  output reg                    address_error_line_n_out,
  output reg                    bus_error_line_n_out,
  output reg                    bus_init_line_n_out,
  output reg                    bus_lock_n_out,
  // Configuration in force
  output wire                   ioq_depth_one_out,
  output wire                   reset_vec_1mb_out,
  output wire [1:0]             bus_freq_out,
  output wire                   low_power_en_out,
  output wire                   streaming_buf_dis_out,
  output wire                   straps_valid_out,
  output reg                    update_trigger_out,
  output wire [63:0]            cache_chunk0_data_out,
  output wire [63:0]            cache_chunk1_data_out
);

  localparam [3:0] SEL_NONE    = 4'h0;
  localparam [3:0] SEL_CFG_LO  = 4'h1;
  localparam [3:0] SEL_CFG_HI  = 4'h2;
  localparam [3:0] SEL_TC      = 4'h3;
  localparam [3:0] SEL_TRIG_LO = 4'h4;
  localparam [3:0] SEL_TRIG_HI = 4'h5;
  localparam [3:0] SEL_C0_LO   = 4'h6;
  localparam [3:0] SEL_C0_HI   = 4'h7;
  localparam [3:0] SEL_C1_LO   = 4'h8;
  localparam [3:0] SEL_C1_HI   = 4'h9;

  // Byte address of a register word from its index
  function [`PCT_ADDR_W-1:0] word_addr;
    input [9:0] idx;
    input       hi;
    begin
      word_addr = {idx, 2'b00} + (hi ? `PCT_HI_OFS : 12'h000);
    end
  endfunction

  function [3:0] decode;
    input [`PCT_ADDR_W-1:0] a;
    begin
      if (a == word_addr(`PCT_IDX_POWERON, 1'b0))          decode = SEL_CFG_LO;
      else if (a == word_addr(`PCT_IDX_POWERON, 1'b1))     decode = SEL_CFG_HI;
      else if (a == word_addr(`PCT_IDX_TEST_CONTROL, 1'b0))    decode = SEL_TC;
      else if (a == word_addr(`PCT_IDX_UPDATE_TRIG, 1'b0)) decode = SEL_TRIG_LO;
      else if (a == word_addr(`PCT_IDX_UPDATE_TRIG, 1'b1)) decode = SEL_TRIG_HI;
      else if (a == word_addr(`PCT_IDX_CHUNK0, 1'b0))      decode = SEL_C0_LO;
      else if (a == word_addr(`PCT_IDX_CHUNK0, 1'b1))      decode = SEL_C0_HI;
      else if (a == word_addr(`PCT_IDX_CHUNK1, 1'b0))      decode = SEL_C1_LO;
      else if (a == word_addr(`PCT_IDX_CHUNK1, 1'b1))      decode = SEL_C1_HI;
      else                                                 decode = SEL_NONE;
    end
  endfunction

  // Byte-lane merge of a write limited to the writable bits
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wdata;
    input [3:0]  strb;
    input [31:0] mask;
    reg   [31:0] lanes;
    begin
      lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
      merge = (old & ~lanes) | (wdata & lanes);
    end
  endfunction

  reg  [31:0] cfg_rw_ff;
  reg  [31:0] tc_ff;
  reg  [63:0] chunk0_ff;
  reg  [63:0] chunk1_ff;
  reg  [31:0] nxt_rdata;
  reg         nxt_slverr;
  wire [31:0] strap_word;
  wire [31:0] cfg_word;
  wire [3:0]  sel;
  wire        setup_phase;
  wire        wr_access;

  pct_strap_latch #(
    .W (32)
  ) u_strap (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .strap_in     (strap_cfg_in),
    .strap_out    (strap_word),
    .captured_out (straps_valid_out)
  );

  // Writable enables plus strap status; reserved bits forced low
  assign cfg_word = (cfg_rw_ff & `PCT_CFG_RW_MASK) | (strap_word & `PCT_CFG_RO_MASK);

  assign sel         = decode(paddr_in);
  assign setup_phase = psel_in & ~penable_in;
  assign wr_access   = psel_in & penable_in & pwrite_in & (sel != SEL_NONE);
  // One wait-free access phase; read data is prepared in the setup cycle
  assign pready_out  = psel_in & penable_in;

  always @* begin
    nxt_rdata  = 32'h00000000;
    nxt_slverr = 1'b0;
    case (sel)
      SEL_CFG_LO:  nxt_rdata = cfg_word;
      SEL_CFG_HI:  nxt_rdata = 32'h00000000;
      SEL_TC:      nxt_rdata = tc_ff & `PCT_TC_RW_MASK;
      SEL_TRIG_LO: nxt_rdata = 32'h00000000;
      SEL_TRIG_HI: nxt_rdata = 32'h00000000;
      SEL_C0_LO:   nxt_rdata = chunk0_ff[31:0];
      SEL_C0_HI:   nxt_rdata = chunk0_ff[63:32];
      SEL_C1_LO:   nxt_rdata = chunk1_ff[31:0];
      SEL_C1_HI:   nxt_rdata = chunk1_ff[63:32];
      default:     nxt_slverr = 1'b1;
    endcase
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      prdata_out  <= 32'h00000000;
      pslverr_out <= 1'b0;
    end else if (setup_phase) begin
      prdata_out  <= pwrite_in ? 32'h00000000 : nxt_rdata;
      pslverr_out <= nxt_slverr;
    end
  end

  // Register writes take effect at the completing access edge
  always @(posedge clk_in) begin
    if (rst_in) begin
      cfg_rw_ff          <= `PCT_CFG_RW_RESET;
      tc_ff              <= `PCT_TC_RESET;
      chunk0_ff          <= 64'h0000000000000000;
      chunk1_ff          <= 64'h0000000000000000;
      update_trigger_out <= 1'b0;
    end else begin
      update_trigger_out <= wr_access & ((sel == SEL_TRIG_LO) | (sel == SEL_TRIG_HI));
      if (wr_access) begin
        case (sel)
          SEL_CFG_LO: cfg_rw_ff <= merge(cfg_rw_ff, pwdata_in, pstrb_in,
                                         `PCT_CFG_RW_MASK);
          SEL_TC:     tc_ff <= merge(tc_ff, pwdata_in, pstrb_in, `PCT_TC_RW_MASK);
          SEL_C0_LO:  chunk0_ff[31:0] <= merge(chunk0_ff[31:0], pwdata_in, pstrb_in,
                                               32'hffffffff);
          SEL_C0_HI:  chunk0_ff[63:32] <= merge(chunk0_ff[63:32], pwdata_in, pstrb_in,
                                                32'hffffffff);
          SEL_C1_LO:  chunk1_ff[31:0] <= merge(chunk1_ff[31:0], pwdata_in, pstrb_in,
                                               32'hffffffff);
          SEL_C1_HI:  chunk1_ff[63:32] <= merge(chunk1_ff[63:32], pwdata_in, pstrb_in,
                                                32'hffffffff);
          default:    cfg_rw_ff <= cfg_rw_ff;
        endcase
      end
    end
  end

  // Error and lock gating; the bus lines are active low and idle high
  always @(posedge clk_in) begin
    if (rst_in) begin
      data_err_flag_out        <= 1'b0;
      resp_err_flag_out        <= 1'b0;
      address_error_line_n_out <= 1'b1;
      bus_error_line_n_out     <= 1'b1;
      bus_init_line_n_out      <= 1'b1;
      bus_lock_n_out           <= 1'b1;
    end else begin
      data_err_flag_out <= data_err_in & cfg_word[`PCT_CFG_DATA_CHK];
      resp_err_flag_out <= (resp_err_in | redundancy_checker_error_input_in)
                           & cfg_word[`PCT_CFG_RESP_CHK];
      address_error_line_n_out <= ~(addr_err_req_in & cfg_word[`PCT_CFG_ADDR_ERR_DRV]);
      bus_error_line_n_out <= ~((bus_error_line_req_initiator_in & cfg_word[`PCT_CFG_BUS_ERROR_LINE_REQ])
                               | (bus_error_line_req_internal_in & cfg_word[`PCT_CFG_BUS_ERROR_LINE_INT]));
      bus_init_line_n_out <= ~(bus_init_line_req_in & cfg_word[`PCT_CFG_BUS_INIT_LINE_DRV]);
      // Split locked accesses may still proceed, only the lock pin stays quiet
      bus_lock_n_out <= ~(lock_req_in & ~(lock_split_in & tc_ff[`PCT_TC_SPLIT_LOCK]));
    end
  end

  assign ioq_depth_one_out     = cfg_word[`PCT_CFG_IOQ_ONE];
  assign reset_vec_1mb_out     = cfg_word[`PCT_CFG_VEC_1MB];
  assign bus_freq_out          = cfg_word[`PCT_CFG_BUSFREQ_LSB+1:`PCT_CFG_BUSFREQ_LSB];
  assign low_power_en_out      = cfg_word[`PCT_CFG_LOW_POWER];
  assign streaming_buf_dis_out = tc_ff[`PCT_TC_STREAM_DIS];
  assign cache_chunk0_data_out = chunk0_ff;
  assign cache_chunk1_data_out = chunk1_ff;

endmodule // pct_ctl

//--- tb/pct_ctl_assertions.sv
/*
  Checker for the power-on configuration bank: bus ready and gated outputs.
  Assumes it is bound to pct_ctl and sees only its ports.
*/
`timescale 1ns/1ps
module pct_ctl_chk (
  input logic clk_in,
  input logic rst_in,
  input logic psel_in,
  input logic penable_in,
  input logic pready_out,
  input logic data_err_in,
  input logic resp_err_in,
  input logic redundancy_checker_error_input_in,
  input logic addr_err_req_in,
  input logic bus_error_line_req_initiator_in,
  input logic bus_error_line_req_internal_in,
  input logic bus_init_line_req_in,
  input logic lock_req_in,
  input logic lock_split_in,
  input logic data_err_flag_out,
  input logic resp_err_flag_out,
  input logic address_error_line_n_out,
  input logic bus_error_line_n_out,
  input logic bus_init_line_n_out,
  input logic bus_lock_n_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  pready_match_a: assert property (pready_out == (psel_in && penable_in))
    else $error("pready does not follow access phase");
  data_flag_cause_a: assert property (data_err_flag_out |-> $past(data_err_in))
    else $error("data error flag without cause");
  resp_flag_cause_a: assert property (resp_err_flag_out |->
    $past(resp_err_in || redundancy_checker_error_input_in))
    else $error("response error flag without cause");
  bus_error_line_cause_a: assert property (!bus_error_line_n_out |->
    $past(bus_error_line_req_initiator_in || bus_error_line_req_internal_in))
    else $error("bus error line without request");
  addr_err_cause_a: assert property (!address_error_line_n_out |-> $past(addr_err_req_in))
    else $error("address error line without request");
  bus_init_line_cause_a: assert property (!bus_init_line_n_out |-> $past(bus_init_line_req_in))
    else $error("bus init line without request");
  lock_unsplit_a: assert property (lock_req_in && !lock_split_in |=> !bus_lock_n_out)
    else $error("lock not driven for unsplit access");
  lock_idle_a: assert property (!lock_req_in |=> bus_lock_n_out)
    else $error("lock driven without request");
endmodule // pct_ctl_chk
bind pct_ctl pct_ctl_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pready_out(pready_out), .data_err_in(data_err_in),
  .resp_err_in(resp_err_in),
  .redundancy_checker_error_input_in(redundancy_checker_error_input_in),
  .addr_err_req_in(addr_err_req_in), .bus_error_line_req_initiator_in(bus_error_line_req_initiator_in),
  .bus_error_line_req_internal_in(bus_error_line_req_internal_in), .bus_init_line_req_in(bus_init_line_req_in),
  .lock_req_in(lock_req_in), .lock_split_in(lock_split_in),
  .data_err_flag_out(data_err_flag_out), .resp_err_flag_out(resp_err_flag_out),
  .address_error_line_n_out(address_error_line_n_out),
  .bus_error_line_n_out(bus_error_line_n_out), .bus_init_line_n_out(bus_init_line_n_out),
  .bus_lock_n_out(bus_lock_n_out));

//--- tb/testbench.sv
/*
  Self-checking bench for pct_ctl: registers over APB, straps, gating, lock.
  Assumes pct_regs.vh on the include path; APB waits end only by the watchdog.
*/
`timescale 1ns/1ps
`include "pct_regs.vh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin bad_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench;
  localparam logic [11:0] A_CFG = {`PCT_IDX_POWERON, 2'b00};
  localparam logic [11:0] A_TC  = {`PCT_IDX_TEST_CONTROL, 2'b00};
  localparam logic [11:0] A_TRIG = {`PCT_IDX_UPDATE_TRIG, 2'b00};
  localparam logic [31:0] STRAP = 32'hfaa5a7ff;
  logic        clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [11:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0, rdata, c;
  logic [8:0]  req = '0;
  logic [3:0]  pstrb_in = 4'hf;
  int          trig_cnt = 0;
  wire         sv, trig;
  logic        rerr;
  int          bad_count = 0, total_checks = 0;
  wire         pready_out, pslverr_out, dflag, rflag, address_error_line_n, bus_error_line_n, bus_init_line_n, lock_n;
  wire         ioq, vec1m, lowp, sbd;
  wire [31:0]  prdata_out;
  wire [1:0]   bfreq;
  wire [63:0]  ch0, ch1;
  always #2.5 clk_in = ~clk_in;
  // Counts trigger pulses edge by edge, so a one-cycle pulse is never missed
  always @(posedge clk_in) trig_cnt <= trig_cnt + trig;
  pct_ctl uut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .strap_cfg_in(STRAP), .data_err_in(req[0]), .resp_err_in(req[1]),
    .redundancy_checker_error_input_in(req[2]), .addr_err_req_in(req[3]),
    .bus_error_line_req_initiator_in(req[4]), .bus_error_line_req_internal_in(req[5]), .bus_init_line_req_in(req[6]),
    .lock_req_in(req[7]), .lock_split_in(req[8]), .data_err_flag_out(dflag),
    .resp_err_flag_out(rflag), .address_error_line_n_out(address_error_line_n),
    .bus_error_line_n_out(bus_error_line_n), .bus_init_line_n_out(bus_init_line_n), .bus_lock_n_out(lock_n),
    .ioq_depth_one_out(ioq), .reset_vec_1mb_out(vec1m), .bus_freq_out(bfreq),
    .low_power_en_out(lowp), .streaming_buf_dis_out(sbd), .straps_valid_out(sv),
    .update_trigger_out(trig), .cache_chunk0_data_out(ch0), .cache_chunk1_data_out(ch1));
  // Entered just after a rising edge; holds the request until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1; penable_in <= 0; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rdata = prdata_out;
    rerr = pslverr_out;
    psel_in <= 0; penable_in <= 0;
    @(posedge clk_in);
  endtask
  task t_straps;
    apb(0, A_CFG, 0);
    `CHK("cfg lo", STRAP & `PCT_CFG_RO_MASK, rdata)
    `CHK("cfg err", 1'b0, rerr)
    `CHK("ioq", STRAP[13], ioq)
    `CHK("vector", STRAP[14], vec1m)
    `CHK("bus freq", STRAP[19:18], bfreq)
    apb(1, A_CFG, '1); apb(0, A_CFG, 0);
    `CHK("cfg rw", (STRAP & `PCT_CFG_RO_MASK) | `PCT_CFG_RW_MASK, rdata)
    `CHK("low power", 1'b1, lowp)
    apb(1, A_CFG + `PCT_HI_OFS, '1); apb(0, A_CFG + `PCT_HI_OFS, 0);
    `CHK("cfg hi", 32'h0, rdata)
  endtask
  // Resp input held low so only the redundancy input can raise the flag
  task t_gating;
    for (int i = 0; i < 8; i++) begin
      c = 32'h1 << i;
      apb(1, A_CFG, c);
      req[6:0] <= 7'h7d;
      @(posedge clk_in); #1;
      `CHK("data flag", c[1], dflag)
      `CHK("resp flag", c[2], rflag)
      `CHK("addr err", ~c[3], address_error_line_n)
      `CHK("bus err", ~(c[4] | c[6]), bus_error_line_n)
      `CHK("bus init", ~c[7], bus_init_line_n)
      @(posedge clk_in);
      req <= '0;
      @(posedge clk_in);
    end
    // Response input alone must also raise the flag
    apb(1, A_CFG, 32'h4);
    req[1] <= 1;
    @(posedge clk_in);
    #1;
    `CHK("resp only", 1'b1, rflag)
    `CHK("low power off", 1'b0, lowp)
    @(posedge clk_in);
    req <= '0;
    @(posedge clk_in);
  endtask
  task t_lock;
    apb(1, A_TC, '1); apb(0, A_TC, 0);
    `CHK("test_control", 32'hc0000000, rdata)
    `CHK("stream dis", 1'b1, sbd)
    req[8:7] <= 2'b11;
    @(posedge clk_in);
    #1;
    `CHK("split lock off", 1'b1, lock_n)
    @(posedge clk_in);
    req[8] <= 0;
    @(posedge clk_in);
    #1;
    `CHK("lock on", 1'b0, lock_n)
    @(posedge clk_in);
    apb(1, A_TC, 0);
    req[8] <= 1;
    @(posedge clk_in);
    #1;
    `CHK("split lock on", 1'b0, lock_n)
    @(posedge clk_in);
    req <= '0;
    @(posedge clk_in);
  endtask
  task t_chunks;
    for (int k = 0; k < 4; k++)
      apb(1, {`PCT_IDX_CHUNK0 + k[1], 2'b00} + (k[0] ? `PCT_HI_OFS : 12'h0), 32'h5a0f3c00 + k);
    for (int k = 0; k < 4; k++) begin
      apb(0, {`PCT_IDX_CHUNK0 + k[1], 2'b00} + (k[0] ? `PCT_HI_OFS : 12'h0), 0);
      `CHK("chunk word", 32'h5a0f3c00 + k, rdata)
    end
    `CHK("chunk0", {32'h5a0f3c01, 32'h5a0f3c00}, ch0)
    `CHK("chunk1", {32'h5a0f3c03, 32'h5a0f3c02}, ch1)
    apb(0, 12'h004, 0);
    `CHK("unmapped err", 1'b1, rerr)
    // Only the two low byte lanes may change
    pstrb_in <= 4'h3;
    apb(1, {`PCT_IDX_CHUNK0, 2'b00}, 32'hffffffff);
    pstrb_in <= 4'hf;
    apb(0, {`PCT_IDX_CHUNK0, 2'b00}, 0);
    `CHK("chunk lanes", 32'h5a0fffff, rdata)
  endtask
  task t_trigger;
    apb(1, A_TRIG, 32'h1);
    apb(0, A_TRIG, 0);
    `CHK("trigger read", 32'h0, rdata)
    `CHK("trigger pulses", 1, trig_cnt)
  endtask
  // Mid-run reset: state cleared, straps recaptured after release
  task t_reset;
    rst_in <= 1;
    repeat (2) @(posedge clk_in);
    #1;
    `CHK("reset chunk0", 64'h0, ch0)
    `CHK("reset straps valid", 1'b0, sv)
    `CHK("reset ioq", 1'b0, ioq)
    @(posedge clk_in);
    rst_in <= 0;
    @(posedge clk_in);
    #1;
    `CHK("straps valid", 1'b1, sv)
    `CHK("ioq recaptured", STRAP[13], ioq)
    @(posedge clk_in);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Whole run is about 140 cycles; this is far beyond it
  initial begin
    #50000;
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 0;
    @(posedge clk_in);
    t_straps;
    t_gating;
    t_lock;
    t_chunks;
    t_trigger;
    t_reset;
    stop_test;
  end
endmodule // testbench
